// File: src/dps_slave.v
/*
 Bus slave of a self-refreshing pseudo-static DRAM on an eight-bit DDR bus.
 Assumes select, bus clock, data and strobe arrive from another domain and the
 bus clock is slow against clk_i (800 ns vs 100 ns), so edges are found by
 sampling. The bus clock may stop between transactions.
*/
`timescale 1ns/1ps
`include "dps_defines.vh"
module dps_slave (
	// System
	input  wire        clk_i,
	input  wire        reset_n_i,
	// Bus pins
	input  wire        select_n_i,
	input  wire        bus_clk_i,
	input  wire [7:0]  data_i,
	output reg  [7:0]  data_o,
	output wire        data_oe_o,
	input  wire        strobe_mask_line_i,
	output reg         strobe_mask_line_o,
	output wire        strobe_mask_line_oe_o,
	// Status
	output wire        busy_o
);
	localparam ST_IDLE = 6'h01;
	localparam ST_CMD  = 6'h02;
	localparam ST_LAT  = 6'h04;
	localparam ST_RD   = 6'h08;
	localparam ST_WR   = 6'h10;
	localparam ST_DONE = 6'h20;
	// Count value at which the last latency edge arrives
	localparam [4:0] LAT_LAST = 5'h01;

	reg [1:0]  sel_sync_q;
	reg [1:0]  clk_sync_q;
	reg [1:0]  msk_sync_q;
	reg [7:0]  dat_s1_q;
	reg [7:0]  dat_s2_q;
	reg        clk_prev_q;
	reg        sel_prev_q;
	reg [5:0]  state_q;
	reg [47:0] cmd_q;
	reg [2:0]  byte_cnt_q;
	reg [4:0]  lat_cnt_q;
	reg        refresh_flag_q;
	reg [`DPS_ADDR_W-1:0] addr_q;
	reg [7:0]  wr_hi_q;
	reg        mask_hi_q;
	reg        wr_en_q;
	reg [1:0]  wr_mask_q;
	reg [15:0] wr_word_q;
	reg        half_q;
	reg [15:0] cfg_q;
	reg [15:0] prefetch_q;
	reg        drive_data_q;
	reg        drive_strobe_q;

	wire        sel_n    = sel_sync_q[1];
	wire        clk_s    = clk_sync_q[1];
	wire        mask_s   = msk_sync_q[1];
	wire        clk_rise = clk_s & ~clk_prev_q;
	wire        clk_fall = ~clk_s & clk_prev_q;
	wire        clk_edge = clk_rise | clk_fall;
	wire        sel_fall = ~sel_n & sel_prev_q;
	wire        sel_rise = sel_n & ~sel_prev_q;
	wire        refresh_pending;
	wire [15:0] rd_word;
	wire        is_read  = cmd_q[`DPS_CMD_DIR_BIT];
	wire        is_reg   = cmd_q[`DPS_CMD_SPACE_BIT];
	wire        is_lin   = cmd_q[`DPS_CMD_BURST_BIT];
	wire [15:0] out_word = is_reg ? cfg_q : rd_word;

	// Next word address: wrapped stays inside the aligned group
	function [`DPS_ADDR_W-1:0] next_addr;
		input [`DPS_ADDR_W-1:0] a;
		input                   linear;
		reg   [`DPS_ADDR_W-1:0] inc;
		begin
			inc = a + 32'h0000_0001;
			if (linear)
				next_addr = inc;
			else
				next_addr = {a[`DPS_ADDR_W-1:`DPS_WRAP_WORDS_LOG2], inc[`DPS_WRAP_WORDS_LOG2-1:0]};
		end
	endfunction

	// Initial latency in bus clock rising edges
	function [4:0] lat_cycles;
		input flagged;
		begin
			if (flagged)
				lat_cycles = {1'b0, `DPS_BASE_LAT_CYC} + {1'b0, `DPS_REFRESH_LAT_CYC};
			else
				lat_cycles = {1'b0, `DPS_BASE_LAT_CYC};
		end
	endfunction

	assign data_oe_o             = drive_data_q;
	assign strobe_mask_line_oe_o = drive_strobe_q;
	assign busy_o                = ~state_q[0];

	// Pins cross into clk_i through two flops each
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			// Select starts as if low, so a frame running at release is not joined halfway
			sel_sync_q <= 2'h0;
			clk_sync_q <= 2'h0;
			msk_sync_q <= 2'h0;
			dat_s1_q   <= 8'h00;
			dat_s2_q   <= 8'h00;
		end else begin
			sel_sync_q <= {sel_sync_q[0], select_n_i};
			clk_sync_q <= {clk_sync_q[0], bus_clk_i};
			msk_sync_q <= {msk_sync_q[0], strobe_mask_line_i};
			dat_s1_q   <= data_i;
			dat_s2_q   <= dat_s1_q;
		end
	end

	// Edge history reads only the second flop of each synchroniser
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			clk_prev_q <= 1'b0;
			sel_prev_q <= 1'b0;
		end else begin
			clk_prev_q <= clk_s;
			sel_prev_q <= sel_n;
		end
	end

	dps_array u_array (
		.clk_i             (clk_i),
		.reset_n_i         (reset_n_i),
		.access_i          (busy_o),
		.wr_en_i           (wr_en_q),
		.wr_mask_i         (wr_mask_q),
		.addr_i            (addr_q[`DPS_MEM_DEPTH_LOG2-1:0]),
		.wr_data_i         (wr_word_q),
		.rd_data_o         (rd_word),
		.refresh_pending_o (refresh_pending)
	);

	// Main transaction sequencer; select edges open and end frames, ST_DONE takes one clk_i, the rest paces off sampled bus clock edges
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_q            <= ST_IDLE;
			cmd_q              <= 48'h0000_0000_0000;
			byte_cnt_q         <= 3'h0;
			lat_cnt_q          <= 5'h00;
			refresh_flag_q     <= 1'b0;
			addr_q             <= 32'h0000_0000;
			wr_hi_q            <= 8'h00;
			mask_hi_q          <= 1'b0;
			wr_en_q            <= 1'b0;
			wr_mask_q          <= 2'h3;
			wr_word_q          <= 16'h0000;
			half_q             <= 1'b0;
			cfg_q              <= `DPS_CFG_RESET;
			prefetch_q         <= 16'h0000;
			data_o             <= 8'h00;
			strobe_mask_line_o <= 1'b0;
			drive_data_q       <= 1'b0;
			drive_strobe_q     <= 1'b0;
		end else begin
			wr_en_q <= 1'b0;
			if (sel_rise) begin
				// Abort leaves the pins quiet so the next frame starts clean
				state_q            <= ST_IDLE;
				drive_data_q       <= 1'b0;
				drive_strobe_q     <= 1'b0;
				data_o             <= 8'h00;
				strobe_mask_line_o <= 1'b0;
				half_q             <= 1'b0;
			end else begin
				case (state_q)
				ST_IDLE: begin
					// Refresh request is taken once per frame; later ones wait
					if (sel_fall) begin
						state_q            <= ST_CMD;
						byte_cnt_q         <= 3'h0;
						refresh_flag_q     <= refresh_pending;
						strobe_mask_line_o <= refresh_pending;
						drive_strobe_q     <= 1'b1;
					end
				end
				ST_CMD: begin
					if (clk_edge) begin
						cmd_q      <= {cmd_q[39:0], dat_s2_q};
						byte_cnt_q <= byte_cnt_q + 3'h1;
						if (byte_cnt_q == `DPS_CA_BYTES - 3'h1) begin
							drive_strobe_q <= 1'b0;
							state_q        <= ST_LAT;
							// Cycles one to four give row, cycle six the word
							addr_q <= {cmd_q[`DPS_CMD_ROW_HI-8:`DPS_CMD_ROW_LO-8],
								dat_s2_q[`DPS_CMD_COL_HI:`DPS_CMD_COL_LO]};
							lat_cnt_q <= lat_cycles(refresh_flag_q);
						end
					end
				end
				ST_LAT: begin
					if (clk_rise) begin
						// Write data begins on the edge after this one
						if (lat_cnt_q == LAT_LAST) begin
							half_q <= 1'b0;
							if (is_read) begin
								state_q            <= ST_RD;
								drive_data_q       <= 1'b1;
								drive_strobe_q     <= 1'b1;
								data_o             <= out_word[15:8];
								strobe_mask_line_o <= 1'b1;
								prefetch_q         <= out_word;
							end else begin
								state_q <= ST_WR;
							end
						end else begin
							lat_cnt_q <= lat_cnt_q - 5'h01;
						end
					end
				end
				ST_RD: begin
					// Second byte on the falling edge, next word on the rising edge
					// The bus clock must leave room for the registered array read
					if (clk_fall) begin
						data_o             <= prefetch_q[7:0];
						strobe_mask_line_o <= 1'b0;
						addr_q             <= next_addr(addr_q, is_lin);
					end else if (clk_rise) begin
						// The array read already ran on the advanced address
						data_o             <= out_word[15:8];
						prefetch_q         <= out_word;
						strobe_mask_line_o <= 1'b1;
					end
				end
				ST_WR: begin
					if (clk_edge) begin
						if (!half_q) begin
							wr_hi_q   <= dat_s2_q;
							mask_hi_q <= mask_s;
							half_q    <= 1'b1;
						end else begin
							// A lone trailing byte never reaches this point and is dropped
							half_q    <= 1'b0;
							wr_word_q <= {wr_hi_q, dat_s2_q};
							wr_mask_q <= {mask_hi_q, mask_s};
							if (is_reg) begin
								if (!mask_hi_q)
									cfg_q[15:8] <= wr_hi_q;
								if (!mask_s)
									cfg_q[7:0] <= dat_s2_q;
								state_q <= ST_DONE;
							end else begin
								wr_en_q <= 1'b1;
								state_q <= ST_DONE;
							end
						end
					end
				end
				ST_DONE: begin
					// Write strobe raised on previous cycle lands on this edge at the old address; advance for next word
					addr_q  <= next_addr(addr_q, is_lin);
					state_q <= ST_WR;
				end
				default: state_q <= ST_IDLE;
				endcase
			end
		end
	end
endmodule // dps_slave

// File: src/dps_defines.vh
/*
 Constants shared by the pseudo-static DRAM bus slave: command bit positions,
 latency and burst figures, refresh timing. Assumes a 10 MHz system clock.
*/
`ifndef DPS_DEFINES_VH
`define DPS_DEFINES_VH
`define DPS_CMD_DIR_BIT      47
`define DPS_CMD_SPACE_BIT    46
`define DPS_CMD_BURST_BIT    45
`define DPS_CMD_ROW_HI       44
`define DPS_CMD_ROW_LO       16
`define DPS_CMD_COL_HI       2
`define DPS_CMD_COL_LO       0
`define DPS_CA_BYTES         3'h6
`define DPS_BASE_LAT_CYC     4'h3
`define DPS_REFRESH_LAT_CYC  4'h3
`define DPS_WRAP_WORDS_LOG2  3
`define DPS_ADDR_W           32
`define DPS_MEM_DEPTH_LOG2   6
`define DPS_REFRESH_PERIOD_NS 4000
`define DPS_CLK_PERIOD_NS    100
`define DPS_REFRESH_BUSY_CYC 4'h4
`define DPS_CFG_RESET        16'h0000
`endif

// File: src/dps_array.v
/*
 Word array with self refresh scheduler. Assumes one clock; access_i marks a
 transfer in progress, during which refresh is deferred and left pending.
*/
`timescale 1ns/1ps
`include "dps_defines.vh"
module dps_array (
	// Clock and reset
	input  wire                          clk_i,
	input  wire                          reset_n_i,
	// Access port
	input  wire                          access_i,
	input  wire                          wr_en_i,
	input  wire [1:0]                    wr_mask_i,
	input  wire [`DPS_MEM_DEPTH_LOG2-1:0] addr_i,
	input  wire [15:0]                   wr_data_i,
	output reg  [15:0]                   rd_data_o,
	// Refresh status
	output wire                          refresh_pending_o
);
	localparam REF_CYC = `DPS_REFRESH_PERIOD_NS / `DPS_CLK_PERIOD_NS;
	reg [15:0] mem_q [0:(1<<`DPS_MEM_DEPTH_LOG2)-1];
	reg [15:0] ref_cnt_q;
	reg        pend_q;
	reg [3:0]  busy_q;
	integer    i;

	assign refresh_pending_o = pend_q;

	// Refresh waits for an idle bus; a long burst leaves it pending
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ref_cnt_q <= 16'h0000;
			pend_q    <= 1'b0;
			busy_q    <= 4'h0;
		end else begin
			if (busy_q != 4'h0) begin
				busy_q <= busy_q - 4'h1;
			end else if (pend_q && !access_i) begin
				busy_q <= `DPS_REFRESH_BUSY_CYC;
				pend_q <= 1'b0;
			end
			// A new request in the cycle a refresh starts must win, or it is lost
			if (ref_cnt_q == REF_CYC[15:0] - 16'h0001) begin
				ref_cnt_q <= 16'h0000;
				pend_q    <= 1'b1;
			end else begin
				ref_cnt_q <= ref_cnt_q + 16'h0001;
			end
		end
	end

	// Byte lanes written only where the mask is low
	always @(posedge clk_i) begin
		if (wr_en_i) begin
			if (!wr_mask_i[1])
				mem_q[addr_i][15:8] <= wr_data_i[15:8];
			if (!wr_mask_i[0])
				mem_q[addr_i][7:0] <= wr_data_i[7:0];
		end
	end

	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			rd_data_o <= 16'h0000;
		else
			rd_data_o <= mem_q[addr_i];
	end
endmodule // dps_array

// File: bench/dps_host_model.sv
/* Host model: frames select, bus clock and bytes for the slave.
 Assumes clk_i at 100 ns; a bus clock half period is four clk_i cycles. */
`timescale 1ns/1ps
`include "dps_defines.vh"
module dps_host_model (
	// Bench clock
	input  wire       clk_i,
	// Bus pins
	output reg        sel_n_o,
	output reg        bclk_o,
	output reg  [7:0] dq_o,
	output reg        sm_o,
	input  wire [7:0] dq_i,
	input  wire       sm_i
);
	reg [8:0] wb [0:31];
	reg [7:0] rb [0:31];
	reg       flag;
	initial begin
		sel_n_o = 1'b1;
		bclk_o = 1'b0;
		dq_o = 8'h00;
		sm_o = 1'b1;
	end
	// Clock stands low between frames
	task automatic frame(input logic rd, sp, lin, input logic [2:0] col, input int nw, cut);
		logic [47:0] ca;
		int          tot, e, d, last;
		ca = {rd, sp, lin, 42'h0, col};
		@(posedge clk_i);
		sel_n_o <= 1'b0;
		dq_o <= ca[47:40];
		repeat (6) @(posedge clk_i);
		flag = sm_i;
		// Waits the longer latency when flagged
		tot = 4 + 2 * (flag ? `DPS_BASE_LAT_CYC + `DPS_REFRESH_LAT_CYC : `DPS_BASE_LAT_CYC) + 2 * nw;
		// Writes need one more full bus clock: data starts after the edge that ends latency
		last = rd ? tot : tot + 2;
		for (e = 0; e <= last && e < cut; e++) begin
			if (e < last) bclk_o <= ~bclk_o;
			repeat (2) @(posedge clk_i);
			d = e - 1 - (tot - 2 * nw);
			if (rd && d >= 0) rb[d] = dq_i;
			d = d + 1;
			// Bytes change mid half period
			if (e < 5) dq_o <= ca[39 - 8 * e -: 8];
			else if (!rd && d >= 0 && d < 2 * nw) {sm_o, dq_o} <= wb[d];
			else if (rd) dq_o <= ~dq_o;
			repeat (2) @(posedge clk_i);
		end
		sel_n_o <= 1'b1;
		bclk_o <= 1'b0;
		repeat (8) @(posedge clk_i);
	endtask
endmodule // dps_host_model

// File: bench/dps_slave_sva.sv
/* Pin checker for the slave, bound to it.
 Assumes clk_i is the only clock and the host keeps select low per frame. */
`timescale 1ns/1ps
module dps_slave_sva (
	// System
	input wire       clk_i,
	input wire       reset_n_i,
	// Bus pins
	input wire       select_n_i,
	input wire       bus_clk_i,
	input wire [7:0] data_i,
	input wire [7:0] data_o,
	input wire       data_oe_o,
	input wire       strobe_mask_line_i,
	input wire       strobe_mask_line_o,
	input wire       strobe_mask_line_oe_o,
	input wire       busy_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	a_reset_float: assert property ($rose(reset_n_i) |-> !data_oe_o && !strobe_mask_line_oe_o && !busy_o)
		else $error("pins driven after reset");
	a_idle_float: assert property (select_n_i [*6] |-> !data_oe_o && !strobe_mask_line_oe_o)
		else $error("pins driven while deselected");
	a_idle_busy: assert property (select_n_i [*6] |-> !busy_o)
		else $error("busy while deselected");
	a_start_cause: assert property ($rose(busy_o) |-> !$past(select_n_i, 2))
		else $error("busy without select");
	a_start_flag: assert property ($rose(busy_o) |-> ##[0:2] strobe_mask_line_oe_o && !data_oe_o)
		else $error("no latency flag at start");
	a_cmd_quiet: assert property ($rose(busy_o) |-> !data_oe_o [*8])
		else $error("data before latency");
	a_read_first: assert property ($rose(data_oe_o) |-> strobe_mask_line_o && strobe_mask_line_oe_o)
		else $error("first read byte without strobe");
	a_read_toggle: assert property (data_oe_o && $changed(bus_clk_i) |->
		##[3:5] ($changed(strobe_mask_line_o) || !data_oe_o))
		else $error("read strobe did not follow clock");
	c_refresh: cover property ($rose(strobe_mask_line_oe_o) ##1 strobe_mask_line_o);
	c_read: cover property ($rose(data_oe_o));
	c_end: cover property (data_oe_o ##1 select_n_i);
endmodule // dps_slave_sva
bind dps_slave dps_slave_sva u_sva (.clk_i(clk_i), .reset_n_i(reset_n_i), .select_n_i(select_n_i),
	.bus_clk_i(bus_clk_i), .data_i(data_i), .data_o(data_o), .data_oe_o(data_oe_o),
	.strobe_mask_line_i(strobe_mask_line_i), .strobe_mask_line_o(strobe_mask_line_o),
	.strobe_mask_line_oe_o(strobe_mask_line_oe_o), .busy_o(busy_o));

// File: bench/dps_slave_tb_top.sv
/* Bench top: writes, reads, register access, abort and reset via the host model.
 Assumes the slave and its defines under src. */
`timescale 1ns/1ps
`include "dps_defines.vh"
module dps_slave_tb_top;
	reg        clk_i = 1'b0;
	reg        reset_n_i = 1'b0;
	wire       sel_n, bclk, h_sm, sm, d_oe, s_oe, s_o, busy;
	wire [7:0] h_dq, dq, d_o;
	int        num_errors = 0;
	int        samples_checked = 0;
	int        i;
	always #50 clk_i = ~clk_i;
	// Device wins the shared lines while it drives them
	assign dq = d_oe ? d_o : h_dq;
	assign sm = s_oe ? s_o : h_sm;
	dps_slave dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .select_n_i(sel_n), .bus_clk_i(bclk),
		.data_i(dq), .data_o(d_o), .data_oe_o(d_oe), .strobe_mask_line_i(sm),
		.strobe_mask_line_o(s_o), .strobe_mask_line_oe_o(s_oe), .busy_o(busy));
	dps_host_model host (.clk_i(clk_i), .sel_n_o(sel_n), .bclk_o(bclk), .dq_o(h_dq), .sm_o(h_sm),
		.dq_i(dq), .sm_i(sm));
	task automatic chk_w(input string n, input logic [15:0] e, g);
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	function automatic logic [15:0] ev(input int a);
		ev = a == 7 ? 16'hbeef : a == 0 ? 16'ha0fe : 16'ha050 + 16'h0101 * a[15:0];
	endfunction
	task automatic rd_chk(input logic lin, input int col, nw, input string n);
		host.frame(1'b1, 1'b0, lin, col[2:0], nw, 99);
		for (i = 0; i < nw; i++)
			chk_w(n, ev(lin ? col + i : (col + i) % 8), {host.rb[2 * i], host.rb[2 * i + 1]});
	endtask
	task t_wr;
		for (i = 0; i < 20; i++)
			host.wb[i] = {1'b0, (i % 2 ? 8'h50 : 8'ha0) + i[8:1]};
		host.frame(1'b0, 1'b0, 1'b1, 3'h0, 10, 99);
		host.wb[0] = 9'h0be;
		host.wb[1] = 9'h0ef;
		host.wb[2] = 9'h1ca;
		host.wb[3] = 9'h0fe;
		host.frame(1'b0, 1'b0, 1'b0, 3'h7, 2, 99);
		chk_w("busy", 16'h0, {15'h0, busy});
		$display("t_wr end");
	endtask
	task t_rd;
		rd_chk(1'b0, 5, 8, "wrap");
		rd_chk(1'b1, 7, 3, "linear");
		$display("t_rd end");
	endtask
	task t_reg;
		host.wb[0] = 9'h012;
		host.wb[1] = 9'h034;
		host.frame(1'b0, 1'b1, 1'b1, 3'h0, 1, 99);
		host.frame(1'b1, 1'b1, 1'b1, 3'h0, 1, 99);
		chk_w("cfg", 16'h1234, {host.rb[0], host.rb[1]});
		$display("t_reg end");
	endtask
	task t_abort;
		host.frame(1'b1, 1'b0, 1'b1, 3'h0, 4, 14);
		chk_w("abort", 16'h0, {13'h0, d_oe, s_oe, busy});
		fork
			host.frame(1'b1, 1'b0, 1'b0, 3'h0, 8, 99);
		join_none
		repeat (40) @(posedge clk_i);
		reset_n_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		chk_w("reset", 16'h0, {13'h0, d_oe, s_oe, busy});
		reset_n_i <= 1'b1;
		wait fork;
		host.frame(1'b1, 1'b1, 1'b1, 3'h0, 1, 99);
		chk_w("cfg_reset", `DPS_CFG_RESET, {host.rb[0], host.rb[1]});
		$display("t_abort end");
	endtask
	task conclude;
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clk_i);
		chk_w("float", 16'h0, {13'h0, d_oe, s_oe, busy});
		repeat (6) @(posedge clk_i);
		reset_n_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		t_wr;
		t_rd;
		t_reg;
		t_abort;
		conclude;
	end
endmodule // dps_slave_tb_top
